// file: verilog/hpsc_slot_regs.sv
// slot control and slot status register word with apb slave and event flags
//
// Implementation choice: the APB slave port.
`default_nettype none
module hpsc_slot_regs
  import hpsc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              slotImplemented,
  input  wire logic              linkActiveSupported,
  input  wire logic              buttonPress,
  input  wire logic              powerFault,
  input  wire logic              retentionLatchSensor,
  input  wire logic              presenceDetect,
  input  wire logic              commandDone,
  input  wire logic              linkActive,
  output logic                   hotplugIrq,
  output logic [1:0]             attnIndicator,
  output logic [1:0]             powerIndicator,
  output logic                   slotPowerOff,
  output logic                   electromechLock,
  output logic                   attnMsgSend,
  output logic                   powerMsgSend
);

  // the mapped offset needs at least eight address bits
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NIN = 7;
  logic [NIN-1:0] pinRaw;
  logic [NIN-1:0] syncA_r;
  logic [NIN-1:0] syncB_r;
  logic [NIN-1:0] syncC_r;
  assign pinRaw = {linkActive, commandDone, presenceDetect, retentionLatchSensor,
                   powerFault, buttonPress, slotImplemented};

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      syncA_r <= '0;
      syncB_r <= '0;
      syncC_r <= '0;
    end
    else
    begin
      syncA_r <= pinRaw;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end

  logic slotImpl;
  logic btnRise;
  logic faultRise;
  logic latchNow;
  logic latchChg;
  logic presNow;
  logic presChg;
  logic cmdRise;
  logic linkChg;
  assign slotImpl  = syncB_r[0];
  assign btnRise   = syncB_r[1] & ~syncC_r[1];
  assign faultRise = syncB_r[2] & ~syncC_r[2];
  assign latchNow  = syncB_r[3];
  assign latchChg  = syncB_r[3] ^ syncC_r[3];
  assign presNow   = syncB_r[4];
  assign presChg   = syncB_r[4] ^ syncC_r[4];
  assign cmdRise   = syncB_r[5] & ~syncC_r[5];
  assign linkChg   = syncB_r[6] ^ syncC_r[6];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic hit;
  logic wrAcc;
  logic wrLo;
  logic wrHi;
  logic wrSt2;
  logic wrSt3;
  assign hit   = (paddr == ADDR_W'(SLOT_CTRL_STAT_OFS));
  // a write lands only at the edge where the master sees pready high
  assign wrAcc = psel & penable & pwrite & hit & pready;
  assign wrLo  = wrAcc & pstrb[0];
  assign wrHi  = wrAcc & pstrb[1];
  assign wrSt2 = wrAcc & pstrb[2];
  assign wrSt3 = wrAcc & pstrb[3];

  // ----------------------------------------------------------------
  // control half
  // ----------------------------------------------------------------
  logic [4:0] evtEn_r;
  logic       hpIntEn_r;
  logic       dllEn_r;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      evtEn_r   <= '0;
      hpIntEn_r <= 1'b0;
    end
    else if (wrLo)
    begin
      evtEn_r   <= pwdata[CTL_CMDDONE_EN:CTL_BTN_EN];
      hpIntEn_r <= pwdata[CTL_HP_INT_EN];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      attnIndicator <= ATTN_RST;
    end
    else if (wrLo)
    begin
      attnIndicator <= pwdata[CTL_ATTN_LO+:2];
    end
  end

  // lamp messages: one pulse per write touching the lane
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      attnMsgSend  <= 1'b0;
      powerMsgSend <= 1'b0;
    end
    else
    begin
      attnMsgSend  <= wrLo;
      powerMsgSend <= wrHi;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      powerIndicator <= PWRIND_RST;
    end
    else if (wrHi)
    begin
      powerIndicator <= pwdata[CTL_PWRIND_LO+:2];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      slotPowerOff    <= 1'b0;
      electromechLock <= 1'b0;
      dllEn_r         <= 1'b0;
    end
    else if (wrHi)
    begin
      slotPowerOff    <= pwdata[CTL_PWR_OFF];
      electromechLock <= pwdata[CTL_LOCK];
      dllEn_r         <= pwdata[CTL_DLL_EN] & linkActiveSupported;
    end
  end

  // ----------------------------------------------------------------
  // status flags: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  logic btnSts_r;
  logic faultSts_r;
  logic latchSts_r;
  logic presSts_r;
  logic cmdSts_r;
  logic dllSts_r;
  logic latchState_r;
  logic presState_r;

  logic clrBtn;
  logic clrFault;
  logic clrPres;
  logic clrCmd;
  logic clrDll;
  assign clrBtn   = wrSt2 & pwdata[STS_BTN];
  assign clrFault = wrSt2 & pwdata[STS_PFAULT];
  assign clrPres  = wrSt2 & pwdata[STS_PRES_CHG];
  assign clrCmd   = wrSt2 & pwdata[STS_CMDDONE];
  assign clrDll   = wrSt3 & pwdata[STS_DLL_CHG];

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      btnSts_r <= 1'b0;
    end
    else
    begin
      btnSts_r <= btnRise | (btnSts_r & ~clrBtn);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      faultSts_r <= 1'b0;
    end
    else
    begin
      faultSts_r <= faultRise | (faultSts_r & ~clrFault);
    end
  end

  // read-only: only reset clears the latch change flag
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      latchSts_r <= 1'b0;
    end
    else
    begin
      latchSts_r <= latchChg | latchSts_r;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      presSts_r <= 1'b0;
    end
    else
    begin
      presSts_r <= presChg | (presSts_r & ~clrPres);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cmdSts_r <= 1'b0;
    end
    else
    begin
      cmdSts_r <= cmdRise | (cmdSts_r & ~clrCmd);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      dllSts_r <= 1'b0;
    end
    else
    begin
      dllSts_r <= (linkChg & linkActiveSupported) | (dllSts_r & ~clrDll);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      latchState_r <= 1'b0;
    end
    else
    begin
      latchState_r <= latchNow;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      presState_r <= 1'b0;
    end
    else
    begin
      presState_r <= presNow | ~slotImpl;
    end
  end

  // ----------------------------------------------------------------
  // read data and interrupt
  // ----------------------------------------------------------------
  logic [31:0] rdWord;
  always_comb
  begin
    rdWord                       = '0;
    rdWord[CTL_CMDDONE_EN:0]     = evtEn_r;
    rdWord[CTL_HP_INT_EN]        = hpIntEn_r;
    rdWord[CTL_ATTN_LO+:2]       = attnIndicator;
    rdWord[CTL_PWRIND_LO+:2]     = powerIndicator;
    rdWord[CTL_PWR_OFF]          = slotPowerOff;
    rdWord[CTL_LOCK]             = electromechLock;
    rdWord[CTL_DLL_EN]           = dllEn_r;
    rdWord[STS_BTN]              = btnSts_r;
    rdWord[STS_PFAULT]           = faultSts_r;
    rdWord[STS_LATCH_CHG]        = latchSts_r;
    rdWord[STS_PRES_CHG]         = presSts_r;
    rdWord[STS_CMDDONE]          = cmdSts_r;
    rdWord[STS_LATCH_OPEN]       = latchState_r;
    rdWord[STS_PRESENT]          = presState_r;
    rdWord[STS_DLL_CHG]          = dllSts_r;
  end

  logic irqNxt;
  assign irqNxt = hpIntEn_r & ((btnSts_r & evtEn_r[CTL_BTN_EN])
                | (faultSts_r & evtEn_r[CTL_PFAULT_EN])
                | (latchSts_r & evtEn_r[CTL_LATCH_EN])
                | (presSts_r & evtEn_r[CTL_PRES_EN])
                | (cmdSts_r & evtEn_r[CTL_CMDDONE_EN])
                | (dllSts_r & dllEn_r));

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      hotplugIrq <= 1'b0;
    end
    else
    begin
      hotplugIrq <= irqNxt;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= psel & penable & ~pready & ~hit;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      prdata <= '0;
    end
    else if (psel & penable & ~pready & ~pwrite & hit)
    begin
      prdata <= rdWord;
    end
    else
    begin
      prdata <= '0;
    end
  end

endmodule
`default_nettype wire

// file: verilog/hpsc_pkg.sv
// package: register map, field positions and reset values of the slot control/status word
`default_nettype none
package hpsc_pkg;
  localparam logic [11:0] SLOT_CTRL_STAT_OFS = 12'h0d8;
  // control half field positions
  localparam int CTL_BTN_EN      = 0;
  localparam int CTL_PFAULT_EN   = 1;
  localparam int CTL_LATCH_EN    = 2;
  localparam int CTL_PRES_EN     = 3;
  localparam int CTL_CMDDONE_EN  = 4;
  localparam int CTL_HP_INT_EN   = 5;
  localparam int CTL_ATTN_LO     = 6;
  localparam int CTL_PWRIND_LO   = 8;
  localparam int CTL_PWR_OFF     = 10;
  localparam int CTL_LOCK        = 11;
  localparam int CTL_DLL_EN      = 12;
  // status half field positions
  localparam int STS_BTN         = 16;
  localparam int STS_PFAULT      = 17;
  localparam int STS_LATCH_CHG   = 18;
  localparam int STS_PRES_CHG    = 19;
  localparam int STS_CMDDONE     = 20;
  localparam int STS_LATCH_OPEN  = 21;
  localparam int STS_PRESENT     = 22;
  localparam int STS_DLL_CHG     = 24;
  // reset values
  localparam logic [1:0] ATTN_RST    = 2'h3;
  localparam logic [1:0] PWRIND_RST  = 2'h1;
  // indicator encodings
  localparam logic [1:0] IND_RSVD    = 2'h0;
  localparam logic [1:0] IND_ON      = 2'h1;
  localparam logic [1:0] IND_BLINK   = 2'h2;
  localparam logic [1:0] IND_OFF     = 2'h3;
endpackage
`default_nettype wire

// file: verification/hpsc_slot_props.sv
// checker for the slot control and status word
`default_nettype none
module hpsc_slot_props
  import hpsc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              slotImplemented,
  input wire logic              hotplugIrq,
  input wire logic [1:0]        attnIndicator,
  input wire logic [1:0]        powerIndicator,
  input wire logic              slotPowerOff,
  input wire logic              attnMsgSend,
  input wire logic              powerMsgSend
);
  // ----------------------------------------
  // master enable shadow and assertions
  // ----------------------------------------
  logic wrAcc;
  logic mEn_r;
  assign wrAcc = psel && penable && pwrite && pready && paddr == SLOT_CTRL_STAT_OFS;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      mEn_r <= 1'b0;
    else if (wrAcc && pstrb[0])
      mEn_r <= pwdata[CTL_HP_INT_EN];
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  sequence accSeq;
    psel && penable && !pready;
  endsequence
  sequence doneSeq;
    psel && penable && pready;
  endsequence
  sequence wrSeq;
    doneSeq ##0 (pwrite && paddr == SLOT_CTRL_STAT_OFS);
  endsequence
  AST_RST_DEF:
    assert property ($fell(sys_rst) |-> attnIndicator == IND_OFF && powerIndicator == IND_ON
      && !slotPowerOff && !hotplugIrq) else $error("bad values after reset");
  AST_ATTN_WR:
    assert property (wrSeq ##0 pstrb[0] |=> attnIndicator == $past(pwdata[7:6]) && attnMsgSend)
      else $error("attention write lost");
  AST_PWR_WR:
    assert property (wrSeq ##0 pstrb[1] |=> powerIndicator == $past(pwdata[9:8])
      && slotPowerOff == $past(pwdata[10]) && powerMsgSend) else $error("power write lost");
  AST_MSG_CAUSE:
    assert property (attnMsgSend |-> $past(wrAcc && pstrb[0])) else $error("stray lamp message");
  AST_IRQ_MASTER:
    assert property (hotplugIrq |-> $past(mEn_r)) else $error("irq without master enable");
  AST_ANSWER:
    assert property (accSeq |=> pready && pslverr == ($past(paddr) != SLOT_CTRL_STAT_OFS))
      else $error("bad apb answer");
  AST_RSVD:
    assert property (pready |-> (prdata & 32'hfe80e000) == 32'h0) else $error("reserved bit set");
  AST_NOSLOT:
    assert property (!slotImplemented [*5] ##0 (pready && !pwrite && !pslverr)
      |-> prdata[STS_PRESENT]) else $error("presence not forced");
endmodule
bind hpsc_slot_regs hpsc_slot_props #(.ADDR_W(ADDR_W)) u_props (.mclk, .sys_rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .slotImplemented,
  .hotplugIrq, .attnIndicator, .powerIndicator, .slotPowerOff, .attnMsgSend, .powerMsgSend);
`default_nettype wire

// file: verification/hpsc_slot_hw.sv
// slot hardware model: event pulses and level toggles on request
`default_nettype none
module hpsc_slot_hw
(
  input  wire logic       mclk,
  input  wire logic [5:0] kick,
  output logic            buttonPress,
  output logic            powerFault,
  output logic            commandDone,
  output logic            retentionLatchSensor,
  output logic            presenceDetect,
  output logic            linkActive
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {buttonPress, powerFault, commandDone} = 3'h0;
    {retentionLatchSensor, presenceDetect, linkActive} = 3'h0;
  end
  always @(posedge mclk)
  begin
    {commandDone, powerFault, buttonPress} <= kick[2:0];
    retentionLatchSensor <= retentionLatchSensor ^ kick[3];
    presenceDetect <= presenceDetect ^ kick[4];
    linkActive <= linkActive ^ kick[5];
  end
endmodule
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the slot control and status word
`default_nettype none
module tb
  import hpsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        slotImplemented = 1, linkActiveSupported = 1, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, r, ctl, sts;
  logic [3:0]  pstrb = 4'hf;
  logic [5:0]  kick = 0;
  logic [1:0]  attnIndicator, powerIndicator, ms;
  logic        pready, pslverr, hotplugIrq, slotPowerOff, electromechLock, attnMsgSend;
  logic        powerMsgSend, buttonPress, powerFault, commandDone, retentionLatchSensor;
  logic        presenceDetect, linkActive;
  int          fail_count = 0, tests_run = 0, seed = 45241;
  always #12.5 mclk = ~mclk;
  hpsc_slot_regs #(.ADDR_W(12)) dut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .slotImplemented, .linkActiveSupported,
    .buttonPress, .powerFault, .retentionLatchSensor, .presenceDetect, .commandDone,
    .linkActive, .hotplugIrq, .attnIndicator, .powerIndicator, .slotPowerOff,
    .electromechLock, .attnMsgSend, .powerMsgSend);
  hpsc_slot_hw hw (.mclk, .kick, .buttonPress, .powerFault, .commandDone,
    .retentionLatchSensor, .presenceDetect, .linkActive);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 20)
    begin
      fail_count++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] d);
    apb(1'b1, SLOT_CTRL_STAT_OFS, d);
    @(posedge mclk);
    ms = {attnMsgSend, powerMsgSend};
    chk("msg", 32'h3, {30'h0, ms});
    ctl = d & 32'h1fff;
    ctl[12] = d[12] & linkActiveSupported;
    sts = sts & ~(d & 32'h011b0000);
  endtask
  task automatic rdc;
    apb(1'b0, SLOT_CTRL_STAT_OFS, 32'h0);
    chk("word", {sts[31:23], sts[22] | ~slotImplemented, sts[21:16], ctl[15:0]}, rd);
    chk("pins", {26'h0, ctl[7:6], ctl[9:8], ctl[10], ctl[11]}, {26'h0, attnIndicator,
      powerIndicator, slotPowerOff, electromechLock});
    chk("irq", {31'h0, ctl[5] && |(sts[31:16] & {7'h0, ctl[12], 3'h0, ctl[4:0]})},
      {31'h0, hotplugIrq});
  endtask
  task automatic evt(input logic [5:0] v);
    @(posedge mclk);
    kick <= v;
    @(posedge mclk);
    kick <= 6'h0;
    repeat (8) @(posedge mclk);
    sts[31:16] = sts[31:16] | {7'h0, v[5] & linkActiveSupported, 3'h0, v[2], v[4], v[3], v[1], v[0]};
    sts[22:21] = sts[22:21] ^ {v[4], v[3]};
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    ctl = 32'h1c0;
    sts = 32'h0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    rdc();
    apb(1'b0, 12'h0dc, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      wr(r);
      rdc();
      r = $random(seed);
      evt(r[5:0]);
      rdc();
    end
    evt(6'h3f);
    wr({16'hffff, ctl[15:0]});
    rdc();
    slotImplemented <= 1'b0;
    repeat (4) @(posedge mclk);
    rdc();
    linkActiveSupported <= 1'b0;
    wr(32'h1000 | ctl);
    evt(6'h20);
    rdc();
    report_and_stop();
  end
endmodule
`default_nettype wire
